//--- inc/mode_map_pkg.sv
// Constants, types and register layout of the mode and resource map block.
// Assumes one 50 MHz clock and a synchronous active-high reset.
package mode_map_pkg;

    // -----------------------------------------------------------------
    // Operating modes, coded as {background, B, A} at reset release
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_SPC_SINGLE = 3'h0,
        MODE_SPC_NARROW = 3'h1,
        MODE_SPC_PERIPH = 3'h2,
        MODE_SPC_WIDE = 3'h3,
        MODE_NRM_SINGLE = 3'h4,
        MODE_NRM_NARROW = 3'h5,
        MODE_FORCED_PERIPH = 3'h6,
        MODE_NRM_WIDE = 3'h7
    } mode_e;

    // Port pin functions.
    localparam logic [1:0] PORT_GPIO = 2'h0;
    localparam logic [1:0] PORT_ADDR_DATA = 2'h1;
    localparam logic [1:0] PORT_ADDR_ONLY = 2'h2;

    typedef struct packed {
        logic [1:0] port_a_fn;
        logic [1:0] port_b_fn;
        logic port_e_bus_ctrl;
        logic port_e_pullup;
        logic port_ab_pullup;
    } port_cfg_s;

    // One-hot resource select.
    typedef struct packed {
        logic none;
        logic ext;
        logic flash;
        logic eeprom;
        logic ram;
        logic regs;
        logic dbg_rom;
        logic dbg_ctrl;
    } sel_s;

    // -----------------------------------------------------------------
    // Register port map and field positions
    // -----------------------------------------------------------------
    localparam logic [2:0] ADDR_MODE = 3'h0;
    localparam logic [2:0] ADDR_REG_POS = 3'h1;
    localparam logic [2:0] ADDR_RAM_POS = 3'h2;
    localparam logic [2:0] ADDR_EE_POS = 3'h3;
    localparam logic [2:0] ADDR_STATUS = 3'h4;
    localparam int MODE_SPECIAL_MODE_LOW_BIT_BIT = 7;
    localparam int MODE_B_BIT = 6;
    localparam int MODE_A_BIT = 5;
    localparam int EE_ON_BIT = 0;

    // Reset positions: registers at 0x0000, RAM 0x0800, EEPROM 0x0D00.
    localparam logic [4:0] REG_POS_RESET = 5'h00;
    localparam logic [4:0] RAM_POS_RESET = 5'h01;
    localparam logic [3:0] EE_POS_RESET = 4'h0;
    localparam logic [3:0] EE_LOW_PAGE = 4'hD;
    localparam logic [7:0] DBG_PAGE = 8'hFF;
    localparam logic [7:0] DBG_CTRL_LAST = 8'h06;

    // Narrow-bus byte sequencer states, Gray coded from idle to high to low; low back to idle flips both bits.
    typedef enum logic [1:0] {
        XF_IDLE = 2'h0,
        XF_HIGH = 2'h1,
        XF_LOW = 2'h3
    } xfer_e;

endpackage

//--- logic/mode_select_and_resource_map.sv
// Mode capture, port configuration, debug state and resource decoder.
// Assumes pins and strobes are synchronous to clk; rst is synchronous.
`timescale 1ns/10ps
module mode_select_and_resource_map (
    input wire logic clk, // 50 MHz clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic background_serial_pin, // Background pin level.
    input wire logic mode_select_b_pin, // Mode pin B level.
    input wire logic mode_select_a_pin, // Mode pin A level.
    output logic background_serial_pin_pullup_en, // Pullup on background pin.
    output logic mode_pulldown_en, // Pulldowns on mode pins.
    input wire logic [2:0] reg_addr, // Register index.
    input wire logic [7:0] reg_wdata, // Register write data.
    input wire logic reg_wr, // Write strobe.
    input wire logic reg_rd, // Read strobe.
    output logic [7:0] reg_rdata, // Read data, cycle after strobe.
    input wire logic acc_valid, // Processor access this cycle.
    input wire logic [15:0] acc_addr, // Processor access address.
    output mode_map_pkg::sel_s acc_sel, // Registered select.
    input wire logic dbg_enable_cmd, // Serial enable command pulse.
    input wire logic dbg_serial_go, // Serial activate command pulse.
    input wire logic enter_background_instruction, // Opcode executed.
    input wire logic dbg_exit, // Debug firmware leaves.
    output logic background_debug_state, // Debug active.
    output logic skip_reset_vector, // Do not fetch reset vector.
    output logic cpu_hold, // Processor kept inactive.
    output mode_map_pkg::port_cfg_s port_cfg, // Port functions.
    input wire logic dbg_acc_req, // Non-intrusive access pending.
    input wire logic dbg_acc_wr, // That access is a write.
    input wire logic [15:0] dbg_acc_addr, // Its address.
    output logic dbg_acc_grant, // Access done this cycle.
    output logic dbg_acc_refused, // Write to read-only memory.
    input wire logic ext_word_req, // 16-bit external transfer pulse.
    output logic ext_cycle, // External bus cycle strobe.
    output logic ext_cycle_high // Cycle carries the high byte.
);
    // -----------------------------------------------------------------
    // Mode capture and software-visible control state
    // -----------------------------------------------------------------
    mode_map_pkg::mode_e mode, next_mode;
    logic mode_written, next_mode_written;
    logic [4:0] reg_pos, next_reg_pos;
    logic [4:0] ram_pos, next_ram_pos;
    logic [3:0] ee_pos, next_ee_pos;
    logic ee_on, next_ee_on;
    logic [2:0] pos_written, next_pos_written;
    logic dbg_enabled, next_dbg_enabled;
    logic next_dbg_active;
    logic [7:0] next_rdata;
    logic normal, single, periph, expanded;

    assign normal = mode[2];
    assign periph = mode == mode_map_pkg::MODE_SPC_PERIPH
        || mode == mode_map_pkg::MODE_FORCED_PERIPH;
    assign single = mode[1:0] == 2'h0;
    assign expanded = !single && !periph;

    // Next values of mode, positions, debug state and read data. The
    // pins are sampled every reset cycle, so the last one kept is the
    // level present at release.
    always_comb
    begin
        next_mode = mode;
        next_mode_written = mode_written;
        next_reg_pos = reg_pos;
        next_ram_pos = ram_pos;
        next_ee_pos = ee_pos;
        next_ee_on = ee_on;
        next_pos_written = pos_written;
        next_dbg_enabled = dbg_enabled;
        next_dbg_active = background_debug_state;
        next_rdata = 8'h00;
        if (reg_wr)
        begin
            case (reg_addr)
                mode_map_pkg::ADDR_MODE:
                begin
                    // Peripheral mode is fixed, and B/A = 1/0 would pick
                    // a peripheral code, special or forced, so never taken.
                    if (!periph && !(normal && mode_written)
                        && !(reg_wdata[mode_map_pkg::MODE_B_BIT]
                        && !reg_wdata[mode_map_pkg::MODE_A_BIT]))
                    begin
                        next_mode = mode_map_pkg::mode_e'({mode[2],
                            reg_wdata[mode_map_pkg::MODE_B_BIT],
                            reg_wdata[mode_map_pkg::MODE_A_BIT]});
                    end
                    next_mode_written = 1'b1;
                end
                mode_map_pkg::ADDR_REG_POS:
                begin
                    // Normal modes lock a position after one write.
                    if (!(normal && pos_written[0]))
                    begin
                        next_reg_pos = reg_wdata[7:3];
                    end
                    next_pos_written[0] = 1'b1;
                end
                mode_map_pkg::ADDR_RAM_POS:
                begin
                    if (!(normal && pos_written[1]))
                    begin
                        next_ram_pos = reg_wdata[7:3];
                    end
                    next_pos_written[1] = 1'b1;
                end
                mode_map_pkg::ADDR_EE_POS:
                begin
                    if (!(normal && pos_written[2]))
                    begin
                        next_ee_pos = reg_wdata[7:4];
                    end
                    next_pos_written[2] = 1'b1;
                    // The EEPROM switch only moves outside single-chip.
                    if (!single)
                    begin
                        next_ee_on = reg_wdata[mode_map_pkg::EE_ON_BIT];
                    end
                end
                default:
                begin
                    next_rdata = 8'h00;
                end
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                mode_map_pkg::ADDR_MODE:
                    next_rdata = {!mode[2] ? 1'b0 : 1'b1, mode[1:0], 5'h00};
                mode_map_pkg::ADDR_REG_POS:
                    next_rdata = {reg_pos, 3'h0};
                mode_map_pkg::ADDR_RAM_POS:
                    next_rdata = {ram_pos, 3'h0};
                mode_map_pkg::ADDR_EE_POS:
                    next_rdata = {ee_pos, 3'h0, ee_on};
                mode_map_pkg::ADDR_STATUS:
                    next_rdata = {5'h00, cpu_hold, dbg_enabled,
                        background_debug_state};
                default:
                    next_rdata = 8'h00;
            endcase
        end
        // Debug activation needs a prior enable outside special single.
        if (dbg_enable_cmd)
        begin
            next_dbg_enabled = 1'b1;
        end
        if (dbg_exit)
        begin
            next_dbg_active = 1'b0;
        end
        if ((dbg_serial_go || enter_background_instruction)
            && dbg_enabled)
        begin
            next_dbg_active = 1'b1;
        end
        if (rst)
        begin
            next_mode = mode_map_pkg::mode_e'({background_serial_pin,
                mode_select_b_pin, mode_select_a_pin});
            next_mode_written = 1'b0;
            next_reg_pos = mode_map_pkg::REG_POS_RESET;
            next_ram_pos = mode_map_pkg::RAM_POS_RESET;
            next_ee_pos = mode_map_pkg::EE_POS_RESET;
            next_ee_on = 1'b1;
            next_pos_written = 3'h0;
            // Special single-chip comes up enabled and active.
            next_dbg_enabled = next_mode == mode_map_pkg::MODE_SPC_SINGLE;
            next_dbg_active = next_dbg_enabled;
            next_rdata = 8'h00;
        end
    end

    // Control registers.
    always_ff @(posedge clk)
    begin
        mode <= next_mode;
        mode_written <= next_mode_written;
        reg_pos <= next_reg_pos;
        ram_pos <= next_ram_pos;
        ee_pos <= next_ee_pos;
        ee_on <= next_ee_on;
        pos_written <= next_pos_written;
        dbg_enabled <= next_dbg_enabled;
        background_debug_state <= next_dbg_active;
        reg_rdata <= next_rdata;
    end

    // -----------------------------------------------------------------
    // Pin pulls and port configuration
    // -----------------------------------------------------------------
    mode_map_pkg::port_cfg_s next_port_cfg;

    // Port functions follow the current mode, so a legal mode write
    // reconfigures the ports two cycles later.
    always_comb
    begin
        next_port_cfg = '0;
        next_port_cfg.port_e_pullup = 1'b1;
        next_port_cfg.port_ab_pullup = 1'b0;
        if (!single)
        begin
            next_port_cfg.port_a_fn = mode_map_pkg::PORT_ADDR_DATA;
            next_port_cfg.port_b_fn = mode[0] && !mode[1]
                ? mode_map_pkg::PORT_ADDR_ONLY
                : mode_map_pkg::PORT_ADDR_DATA;
            next_port_cfg.port_e_bus_ctrl = 1'b1;
        end
    end

    // Pulls sit on the mode pins while reset is held, one cycle delayed.
    always_ff @(posedge clk)
    begin
        background_serial_pin_pullup_en <= rst;
        mode_pulldown_en <= rst;
        port_cfg <= next_port_cfg;
        cpu_hold <= !rst && periph;
        skip_reset_vector <= next_mode == mode_map_pkg::MODE_SPC_SINGLE;
    end

    // -----------------------------------------------------------------
    // Resource decoder
    // -----------------------------------------------------------------
    mode_map_pkg::sel_s next_acc_sel, dbg_sel;
    logic next_grant, next_refused;

    // Fixed precedence over the current map; the chain of else-ifs
    // guarantees a single select. Map writes are seen from the next
    // cycle, so a select changes two cycles after the write.
    function automatic mode_map_pkg::sel_s decode(input logic [15:0] a);
        mode_map_pkg::sel_s s;
        s = '0;
        if (background_debug_state
            && a[15:8] == mode_map_pkg::DBG_PAGE)
        begin
            if (a[7:0] <= mode_map_pkg::DBG_CTRL_LAST)
                s.dbg_ctrl = 1'b1;
            else
                s.dbg_rom = 1'b1;
        end
        else if (a[15:11] == reg_pos && a[10:9] == 2'h0)
            s.regs = 1'b1;
        else if (a[15:11] == ram_pos && !a[10])
            s.ram = 1'b1;
        else if (ee_on && a[15:12] == ee_pos
            && a[11:8] >= mode_map_pkg::EE_LOW_PAGE)
            s.eeprom = 1'b1;
        else if (single && a[15])
            s.flash = 1'b1;
        else if (expanded)
            s.ext = 1'b1;
        else
            s.none = 1'b1;
        return s;
    endfunction

    // Debug accesses are served only in cycles the processor leaves idle.
    always_comb
    begin
        next_acc_sel = acc_valid ? decode(acc_addr) : '0;
        dbg_sel = decode(dbg_acc_addr);
        next_grant = dbg_acc_req && !acc_valid && !rst;
        next_refused = next_grant && dbg_acc_wr
            && (dbg_sel.eeprom || dbg_sel.flash);
        if (rst)
        begin
            next_acc_sel = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        acc_sel <= next_acc_sel;
        dbg_acc_grant <= next_grant;
        dbg_acc_refused <= next_refused;
    end

    // -----------------------------------------------------------------
    // External byte sequencer
    // -----------------------------------------------------------------
    mode_map_pkg::xfer_e xf, next_xf;
    logic next_ext_cycle, next_ext_high;

    // Narrow modes split a word into two cycles, high byte first; wide
    // modes run it as one cycle. Requests during a split are dropped.
    always_comb
    begin
        next_xf = xf;
        next_ext_cycle = 1'b0;
        next_ext_high = 1'b0;
        case (xf)
            mode_map_pkg::XF_IDLE:
            begin
                if (ext_word_req && expanded)
                begin
                    next_ext_cycle = 1'b1;
                    if (mode[0] && !mode[1])
                    begin
                        next_xf = mode_map_pkg::XF_HIGH;
                        next_ext_high = 1'b1;
                    end
                end
            end
            mode_map_pkg::XF_HIGH:
            begin
                next_xf = mode_map_pkg::XF_LOW;
                next_ext_cycle = 1'b1;
            end
            mode_map_pkg::XF_LOW:
                next_xf = mode_map_pkg::XF_IDLE;
            default:
                next_xf = mode_map_pkg::XF_IDLE;
        endcase
        if (rst)
        begin
            next_xf = mode_map_pkg::XF_IDLE;
            next_ext_cycle = 1'b0;
            next_ext_high = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        xf <= next_xf;
        ext_cycle <= next_ext_cycle;
        ext_cycle_high <= next_ext_high;
    end

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_mode_latch;
        $fell(rst) |-> mode == $past({background_serial_pin,
            mode_select_b_pin, mode_select_a_pin});
    endproperty
    a_mode_latch: assert property (p_mode_latch)
        else $error("Mode not latched at reset release.");

    // The pulls are a registered copy of reset, so they drop one edge
    // after release; the first edge after release is not judged.
    property p_pulls;
        !$past(rst) |-> !background_serial_pin_pullup_en && !mode_pulldown_en;
    endproperty
    a_pulls: assert property (p_pulls)
        else $error("Mode pin pulls left on after reset.");

    property p_ssc_debug;
        $fell(rst) && mode == mode_map_pkg::MODE_SPC_SINGLE
            |-> background_debug_state && skip_reset_vector;
    endproperty
    a_ssc_debug: assert property (p_ssc_debug)
        else $error("Special single-chip not in debug at reset.");

    property p_need_enable;
        !dbg_enabled && !$past(background_debug_state)
            |-> !background_debug_state;
    endproperty
    a_need_enable: assert property (p_need_enable)
        else $error("Debug activated without enable.");

    property p_activate;
        dbg_enabled && enter_background_instruction && !dbg_exit
            |=> background_debug_state;
    endproperty
    a_activate: assert property (p_activate)
        else $error("Background opcode did not activate debug.");

    property p_onehot;
        $past(acc_valid) && !$past(rst) |-> $onehot(acc_sel);
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("Resource select not one-hot.");

    property p_dbg_page;
        acc_valid && background_debug_state
            && acc_addr[15:8] == mode_map_pkg::DBG_PAGE
            |=> acc_sel.dbg_rom || acc_sel.dbg_ctrl;
    endproperty
    a_dbg_page: assert property (p_dbg_page)
        else $error("Debug page not claimed by debug ROM.");

    property p_narrow_split;
        ext_cycle && ext_cycle_high |=> ext_cycle && !ext_cycle_high
            ##1 !ext_cycle;
    endproperty
    a_narrow_split: assert property (p_narrow_split)
        else $error("Narrow transfer not split high then low.");

    property p_periph_fixed;
        periph |=> $stable(mode);
    endproperty
    a_periph_fixed: assert property (p_periph_fixed)
        else $error("Peripheral mode left without reset.");

    property p_never_periph;
        !periph |=> !periph;
    endproperty
    a_never_periph: assert property (p_never_periph)
        else $error("Peripheral mode reached by a write.");

    property p_idle_grant;
        dbg_acc_grant |-> !$past(acc_valid);
    endproperty
    a_idle_grant: assert property (p_idle_grant)
        else $error("Debug access granted in a busy cycle.");

    c_ssc: cover property ($fell(rst) && background_debug_state);
    c_split: cover property (ext_cycle_high ##1 ext_cycle);
    c_ext: cover property (acc_sel.ext);
    c_refuse: cover property (dbg_acc_refused);
endmodule

//--- bench/ext_bus_model.sv
// External memory bus stand-in that records every bus cycle it sees.
// Assumes the block's cycle strobes are registered on the same clock.
`timescale 1ns/10ps
module ext_bus_model (
    input wire logic clk, // Bus clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic ext_cycle, // Bus cycle strobe.
    input wire logic ext_cycle_high, // Cycle carries the high byte.
    output logic [7:0] n_cyc, // Cycles seen since reset.
    output logic [3:0] high_hist // High-byte markers, newest in bit 0.
);
    // Keep the marker history so the bench can see the byte order.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            n_cyc <= 8'h00;
            high_hist <= 4'h0;
        end
        else if (ext_cycle)
        begin
            n_cyc <= n_cyc + 8'h01;
            high_hist <= {high_hist[2:0], ext_cycle_high};
        end
    end
endmodule

//--- bench/mode_select_and_resource_map_tb.sv
// Self-checking bench for the mode and resource map block.
// Assumes a 50 MHz clock and a synchronous active-high reset.
`timescale 1ns/10ps
module mode_select_and_resource_map_tb;
    logic clk, rst, background_serial_pin, mode_select_b_pin;
    logic mode_select_a_pin, background_serial_pin_pullup_en, mode_pulldown_en;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d, n_cyc;
    logic reg_wr, reg_rd, acc_valid, dbg_enable_cmd, dbg_serial_go;
    logic [15:0] acc_addr, dbg_acc_addr;
    mode_map_pkg::sel_s acc_sel;
    mode_map_pkg::port_cfg_s port_cfg;
    logic enter_background_instruction, dbg_exit, background_debug_state;
    logic skip_reset_vector, cpu_hold, dbg_acc_req, dbg_acc_wr;
    logic dbg_acc_grant, dbg_acc_refused, ext_word_req, ext_cycle;
    logic ext_cycle_high;
    logic [3:0] high_hist;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;

    mode_select_and_resource_map mode_select_and_resource_map_inst (.clk,
        .rst, .background_serial_pin, .mode_select_b_pin, .mode_select_a_pin,
        .background_serial_pin_pullup_en, .mode_pulldown_en, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .acc_valid, .acc_addr, .acc_sel, .dbg_enable_cmd,
        .dbg_serial_go, .enter_background_instruction, .dbg_exit,
        .background_debug_state, .skip_reset_vector, .cpu_hold, .port_cfg,
        .dbg_acc_req, .dbg_acc_wr, .dbg_acc_addr, .dbg_acc_grant,
        .dbg_acc_refused, .ext_word_req, .ext_cycle, .ext_cycle_high);
    ext_bus_model ext_bus_model_inst (.clk, .rst, .ext_cycle,
        .ext_cycle_high, .n_cyc, .high_hist);

    // Free-running clock; the cycle ceiling cuts a hang short.
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            test_done();
        end
    end

    task automatic test_done();
        if (errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] exp,
        input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Pins are held through reset; the mode is what they show at release.
    task automatic reset_mode(input logic [2:0] m);
        @(posedge clk);
        rst <= 1'b1;
        {background_serial_pin, mode_select_b_pin, mode_select_a_pin} <= m;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1 check("pulls", 16'h3,
            16'({background_serial_pin_pullup_en, mode_pulldown_en}));
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Select bits, msb first: none ext flash eeprom ram regs rom ctrl.
    task automatic acc(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_addr <= a;
        @(posedge clk);
        acc_valid <= 1'b0;
        #1 check("acc_sel", {8'h00, exp}, {8'h00, acc_sel});
    endtask

    // Every pin code once; peripheral codes leave port use unspecified.
    // No debug command is sent while a peripheral code is latched.
    task automatic t_modes();
        logic [3:0] fn;
        for (int i = 0; i < 8; i++)
        begin
            reset_mode(i[2:0]);
            fn = (i[1:0] == 2'h3) ? 4'h5 : (i[1:0] == 2'h1) ? 4'h6 : 4'h0;
            check("skip", 16'(i == 0), 16'(skip_reset_vector));
            check("dbg", 16'(i == 0), 16'(background_debug_state));
            check("hold", 16'(i == 2 || i == 6), 16'(cpu_hold));
            if (i != 2 && i != 6)
                check("fn", 16'(fn), 16'(port_cfg[6:3]));
            if (i == 3)
                check("e_bus", 16'h1, 16'(port_cfg[2]));
            if (i == 4)
                check("pullup", 16'h2, 16'(port_cfg[1:0]));
        end
    endtask

    // Normal expanded wide: default map, relocation, debug activation.
    task automatic t_map();
        acc(16'h0000, 8'h04);
        acc(16'h0D00, 8'h10);
        acc(16'h4000, 8'h40);
        wr(mode_map_pkg::ADDR_REG_POS, 8'h08);
        acc(16'h0800, 8'h04);
        acc(16'h0A00, 8'h08);
        wr(mode_map_pkg::ADDR_REG_POS, 8'h10);
        rd(mode_map_pkg::ADDR_REG_POS, d);
        check("reg_pos", 16'h08, 16'(d));
        @(posedge clk);
        dbg_serial_go <= 1'b1;
        @(posedge clk);
        dbg_serial_go <= 1'b0;
        dbg_enable_cmd <= 1'b1;
        @(posedge clk);
        dbg_enable_cmd <= 1'b0;
        enter_background_instruction <= 1'b1;
        #1 check("dbg", 16'h0, 16'(background_debug_state));
        @(posedge clk);
        enter_background_instruction <= 1'b0;
        acc(16'hFF10, 8'h02);
        acc(16'hFF06, 8'h01);
        @(posedge clk);
        dbg_exit <= 1'b1;
        @(posedge clk);
        dbg_exit <= 1'b0;
        rd(mode_map_pkg::ADDR_STATUS, d);
        check("status", 16'h02, 16'(d));
    endtask

    // Special narrow split, mode rewrites, then a wide single cycle.
    task automatic t_narrow();
        reset_mode(3'h1);
        @(posedge clk);
        ext_word_req <= 1'b1;
        @(posedge clk);
        ext_word_req <= 1'b0;
        repeat (4) @(posedge clk);
        #1 check("split", 16'h0202, {n_cyc, 6'h0, high_hist[1:0]});
        wr(mode_map_pkg::ADDR_MODE, 8'h60);
        wr(mode_map_pkg::ADDR_MODE, 8'h40);
        rd(mode_map_pkg::ADDR_MODE, d);
        check("mode", 16'h3, 16'(d[6:5]));
        @(posedge clk);
        ext_word_req <= 1'b1;
        @(posedge clk);
        ext_word_req <= 1'b0;
        repeat (3) @(posedge clk);
        #1 check("wide", 16'h3, 16'(n_cyc));
    endtask

    // Normal single-chip: flash high, nothing external, read-only debug.
    task automatic t_single();
        reset_mode(3'h4);
        acc(16'h8000, 8'h20);
        acc(16'h4000, 8'h80);
        @(posedge clk);
        dbg_acc_req <= 1'b1;
        dbg_acc_wr <= 1'b1;
        dbg_acc_addr <= 16'h8000;
        @(posedge clk);
        dbg_acc_req <= 1'b0;
        #1 check("grant", 16'h3,
            16'({dbg_acc_grant, dbg_acc_refused}));
    endtask

    initial
    begin
        {rst, background_serial_pin, mode_select_b_pin} = 3'h4;
        {mode_select_a_pin, reg_wr, reg_rd, acc_valid, dbg_exit} = 5'h0;
        {dbg_enable_cmd, dbg_serial_go, enter_background_instruction} = 3'h0;
        {dbg_acc_req, dbg_acc_wr, ext_word_req} = 3'h0;
        {reg_addr, reg_wdata, acc_addr, dbg_acc_addr} = 43'h0;
        repeat (3) @(posedge clk);
        t_modes();
        t_map();
        t_narrow();
        t_single();
        test_done();
    end
endmodule
